// *** logic/mlsi_regs.vh ***
// Register offsets, field positions, reset values and tie-off constants for the interconnect.
`ifndef MLSI_REGS_VH
`define MLSI_REGS_VH

// Register byte offsets on the bus.
`define MLSI_OFF_CTRL        4'h0
`define MLSI_OFF_STATUS      4'h4
`define MLSI_OFF_MODE        4'h8
`define MLSI_OFF_CHAN        4'hc

// Control register fields.
`define MLSI_CTRL_TSEL_LSB   0
`define MLSI_CTRL_TSEL_MSB   1
`define MLSI_CTRL_OVA_BIT    2
`define MLSI_CTRL_OCA_BIT    3
`define MLSI_CTRL_RESET      4'h1

// Converter trigger source codes.
`define MLSI_TSEL_TIMER_OC2  2'h0
`define MLSI_TSEL_TRIG_OUT0  2'h1
`define MLSI_TSEL_PWM_RELOAD 2'h2

// Status register fields.
`define MLSI_ST_FAULT_LSB    0
`define MLSI_ST_FAULT_MSB    5
`define MLSI_ST_MODE_BIT     8
`define MLSI_ST_DEBUG_BIT    9
`define MLSI_ST_INTERNAL_BIT 10
`define MLSI_ST_RSVD_BIT     11

// Mode register field and value meaning.
`define MLSI_MODE_BIT        0
`define MLSI_MODE_NORMAL     1'b1
`define MLSI_MODE_SPECIAL    1'b0

// Channel select decode: internal channel n is base plus n.
`define MLSI_CH_INT_BASE     6'h08
`define MLSI_CH_INT_MASK     6'h38
`define MLSI_CH_IDX_TEMP_BG  3'h0
`define MLSI_CH_IDX_PHASE    3'h1
`define MLSI_CH_IDX_DCLINK   3'h3
`define MLSI_CH_IDX_SUPPLY   3'h4
`define MLSI_CH_IDX_RSVD5    3'h5
`define MLSI_CH_IDX_RSVD6    3'h6
`define MLSI_CH_IDX_DVBE     3'h7

// Tie-off values.
`define MLSI_EDGE_SEL_BOTH   2'h3
`define MLSI_ASYNC_EVT_TIE   1'b0
`define MLSI_FLASH_DIV_ERASE 8'h05
`define MLSI_STATUS_SIDE_TIE 1'b1

// AHB constants.
`define MLSI_HTRANS_NONSEQ   2'h2
`define MLSI_HRESP_OKAY      1'b0
`define MLSI_WORD_ZERO       32'h00000000

`endif

// *** logic/mlsi_top.v ***
// Device-level interconnect around the motor-control loop, with an AHB-Lite control slave.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "mlsi_regs.vh"

// Overview of operation
// RL1: Converter sequence abort is tied inactive.
// RL2: Trigger unit reload restarts the converter.
// RL3: Global load-ok strobe drives converter load-ok.
// RL4: Converter trigger muxed: timer, trigger out0, reload.
// RL5: Channel field selects internal converter channels.
// RL6: High-voltage inputs 2..0 feed channels 11..9.
// RL7: Trigger unit async reload qualifier tied inactive.
// RL8: PWM 0..3 drive phase gates in order.
// RL9: Fault 4 from overvoltage or overcurrent assign-0.
// RL10: Fault 1 ORs desat1, assigned overcurrent, overvoltage.
// RL11: Fault 0 ORs desat0 and assigned overcurrent.
// RL12: PWM async event 0, edge select 3.
// RL13: Only PWM reload A reaches trigger unit.
// RL14: Debug serial clock from internal reference oscillator.
// RL15: Debug fast clock is the bus clock.
// RL16: Debug erase command drives flash erase-all request.
// RL17: Debug erase forces flash divider to 0x05.
// RL18: Host keeps bus frequency until erase launched.
// RL19: Mode pin captured into mode bit at reset release.
// RL20: Mode one is normal, zero is special.
// RL21: Special mode leaves reset with debug active.
// RL22: Reload and load-ok also reach driver and trigger.
// RL23: Fault 2 tied, 3 undervoltage, 5 external pin.
module mlsi_top (
    input  wire        clk,
    input  wire        rstn,
    // AHB-Lite slave.
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output wire [31:0] hrdata,
    // Loop events.
    input  wire        pwm_reload_a,
    input  wire        pwm_reload_b,
    input  wire        pwm_reload_c,
    input  wire        trigger_unit_reload,
    input  wire        trigger_unit_output_0,
    input  wire        timer_zero_oc2,
    input  wire        glb_load_ok,
    output wire        trigger_unit_reload_in,
    output wire        trigger_unit_load_ok,
    output wire        async_reload_qualifier,
    output wire        converter_restart,
    output wire        converter_load_ok,
    output wire        converter_seq_abort,
    output wire        converter_trigger,
    output wire        gate_driver_unit_reload,
    output wire        gate_driver_unit_phase_mux_sel,
    // Converter channels.
    input  wire [5:0]  channel_select_field,
    input  wire [2:0]  high_voltage_port_input,
    output wire [11:9] converter_external_channel,
    output wire        sel_temp_bandgap,
    output wire        sel_phase_mux,
    output wire        sel_dc_link,
    output wire        sel_supply_sense,
    output wire        sel_dvbe_temp,
    output wire        sel_reserved,
    // PWM and gate driver.
    input  wire [3:0]  pwm_channel,
    output wire [1:0]  high_side_gate,
    output wire [1:0]  low_side_gate,
    input  wire [1:0]  drv_desaturation,
    input  wire        drv_overcurrent,
    input  wire        drv_overvoltage,
    input  wire        low_side_supply_undervoltage,
    input  wire        external_fault_pin,
    input  wire [1:0]  drv_phase_status,
    output wire        pwm_fault_input_0,
    output wire        pwm_fault_input_1,
    output wire        pwm_fault_input_2,
    output wire        pwm_fault_input_3,
    output wire        pwm_fault_input_4,
    output wire        pwm_fault_input_5,
    output wire [2:0]  pwm_phase_status,
    output wire        pwm_async_event,
    output wire [1:0]  pwm_async_event_edge_sel,
    // Debug and flash.
    input  wire        internal_reference_osc_clock,
    output wire        debug_serial_clock,
    output wire        debug_fast_clock,
    input  wire        debug_erase_flash_cmd,
    input  wire        debug_exit,
    output wire        flash_erase_all_req,
    output wire        flash_clkdiv_force,
    output wire [7:0]  flash_clock_divider_value,
    // Chip mode.
    input  wire        mode_select_input,
    output wire        mode_normal,
    output wire        background_debug_state
);

    reg  [3:0]  ctrl_q;
    reg         mode_q;
    reg         debug_q;
    reg         rstn_q;
    reg  [1:0]  mode_sync_q;
    reg  [1:0]  pwm_fault_input_5_sync_q;
    reg  [2:0]  hv_sync0_q;
    reg  [2:0]  hv_sync1_q;
    reg         wr_pend_q;
    reg  [3:0]  wr_addr_q;
    reg  [31:0] rdata_q;
    reg  [31:0] rdata_d;
    reg         conv_trig_d;
    wire        addr_phase;
    wire        oca;
    wire        ova;
    wire        ch_internal;
    wire [2:0]  ch_idx;
    wire [5:0]  fault_vec;

    // Decodes one internal channel index against the converter's command field.
    function ch_hit;
        input [5:0] field;
        input [2:0] idx;
        begin
            ch_hit = ((field & `MLSI_CH_INT_MASK) == `MLSI_CH_INT_BASE) &&
                     (field[2:0] == idx);
        end
    endfunction

    // Tie-offs that keep unused module inputs in a known inactive state.
    assign converter_seq_abort      = 1'b0;                    // [RL1]
    assign async_reload_qualifier   = 1'b0;                    // [RL7]
    assign pwm_async_event          = `MLSI_ASYNC_EVT_TIE;     // [RL12]
    assign pwm_async_event_edge_sel = `MLSI_EDGE_SEL_BOTH;     // [RL12]
    assign pwm_phase_status = {`MLSI_STATUS_SIDE_TIE, drv_phase_status};

    // Loop events are same-clock pulses and pass straight through to keep loop latency at zero.
    // Reload B and C are deliberately left unread.
    assign trigger_unit_reload_in         = pwm_reload_a;         // [RL13]
    assign converter_restart              = trigger_unit_reload;  // [RL2]
    assign gate_driver_unit_reload        = trigger_unit_reload;  // [RL22]
    assign converter_load_ok              = glb_load_ok;          // [RL3]
    assign trigger_unit_load_ok           = glb_load_ok;          // [RL22]
    assign gate_driver_unit_phase_mux_sel = glb_load_ok;          // [RL22]

    // Converter trigger multiplexer; an unused select code gives no trigger.
    always @* begin
        case (ctrl_q[`MLSI_CTRL_TSEL_MSB:`MLSI_CTRL_TSEL_LSB])
            `MLSI_TSEL_TIMER_OC2:  conv_trig_d = timer_zero_oc2;         // [RL4]
            `MLSI_TSEL_TRIG_OUT0:  conv_trig_d = trigger_unit_output_0;  // [RL4]
            `MLSI_TSEL_PWM_RELOAD: conv_trig_d = pwm_reload_a;           // [RL4]
            default:               conv_trig_d = 1'b0;
        endcase
    end
    assign converter_trigger = conv_trig_d;

    // Internal channel selects from the six-bit command field.
    assign ch_internal      = ((channel_select_field & `MLSI_CH_INT_MASK) == `MLSI_CH_INT_BASE);
    assign ch_idx           = channel_select_field[2:0];
    assign sel_temp_bandgap = ch_hit(channel_select_field, `MLSI_CH_IDX_TEMP_BG);  // [RL5]
    assign sel_phase_mux    = ch_hit(channel_select_field, `MLSI_CH_IDX_PHASE);    // [RL5]
    assign sel_dc_link      = ch_hit(channel_select_field, `MLSI_CH_IDX_DCLINK);   // [RL5]
    assign sel_supply_sense = ch_hit(channel_select_field, `MLSI_CH_IDX_SUPPLY);   // [RL5]
    assign sel_dvbe_temp    = ch_hit(channel_select_field, `MLSI_CH_IDX_DVBE);     // [RL5]
    assign sel_reserved     = ch_hit(channel_select_field, `MLSI_CH_IDX_RSVD5) |
                              ch_hit(channel_select_field, `MLSI_CH_IDX_RSVD6);   // [RL5]

    // High-voltage pins are asynchronous, so they pass two flip-flops first.
    always @(posedge clk) begin
        hv_sync0_q <= high_voltage_port_input;
        hv_sync1_q <= hv_sync0_q;
    end
    assign converter_external_channel = hv_sync1_q;  // [RL6]

    // Gate drive keeps the PWM timing untouched, so no register sits in the path.
    assign high_side_gate = {pwm_channel[2], pwm_channel[0]};  // [RL8]
    assign low_side_gate  = {pwm_channel[3], pwm_channel[1]};  // [RL8]

    // External fault pin synchroniser; only the second stage is read.
    always @(posedge clk) begin
        pwm_fault_input_5_sync_q <= {pwm_fault_input_5_sync_q[0], external_fault_pin};
    end

    // Fault routing; the assign bits move overcurrent and overvoltage between inputs.
    assign oca = ctrl_q[`MLSI_CTRL_OCA_BIT];
    assign ova = ctrl_q[`MLSI_CTRL_OVA_BIT];
    assign pwm_fault_input_0 = drv_desaturation[0] | (drv_overcurrent & oca);  // [RL11]
    assign pwm_fault_input_1 = drv_desaturation[1] | (drv_overcurrent & oca) |
                               (drv_overvoltage & ova);                      // [RL10]
    assign pwm_fault_input_2 = 1'b0;                                           // [RL23]
    assign pwm_fault_input_3 = low_side_supply_undervoltage;                   // [RL23]
    assign pwm_fault_input_4 = (drv_overvoltage & ~ova) |
                               (drv_overcurrent & ~oca);                     // [RL9]
    assign pwm_fault_input_5 = pwm_fault_input_5_sync_q[1];                               // [RL23]
    assign fault_vec = {pwm_fault_input_5, pwm_fault_input_4, pwm_fault_input_3,
                        pwm_fault_input_2, pwm_fault_input_1, pwm_fault_input_0};

    // Debug clocks and flash erase hookup are plain wiring.
    assign debug_serial_clock        = internal_reference_osc_clock;  // [RL14]
    assign debug_fast_clock          = clk;                           // [RL15]
    assign flash_erase_all_req       = debug_erase_flash_cmd;         // [RL16]
    assign flash_clkdiv_force        = debug_erase_flash_cmd;         // [RL17]
    assign flash_clock_divider_value = `MLSI_FLASH_DIV_ERASE;         // [RL17]
    // The divider value is only right while the bus runs at its reset rate.  [RL18]

    // Mode pin synchroniser runs through reset so it already holds the pin level at release.
    always @(posedge clk) begin
        mode_sync_q <= {mode_sync_q[0], mode_select_input};
    end

    // Mode capture at the reset release edge and debug state entry.
    always @(posedge clk) begin
        rstn_q <= rstn;
        if (!rstn) begin
            mode_q  <= `MLSI_MODE_NORMAL;
            debug_q <= 1'b0;
        end else if (!rstn_q) begin
            mode_q  <= mode_sync_q[1];                                   // [RL19]
            debug_q <= (mode_sync_q[1] == `MLSI_MODE_SPECIAL);           // [RL20] [RL21]
        end else begin
            if (wr_pend_q && (wr_addr_q == `MLSI_OFF_MODE) &&
                (mode_q == `MLSI_MODE_SPECIAL) && hwdata[`MLSI_MODE_BIT]) begin
                // Only special to normal is allowed; the way back needs a reset.
                mode_q <= `MLSI_MODE_NORMAL;                             // [RL19]
            end
            if (debug_exit) begin
                debug_q <= 1'b0;
            end
        end
    end
    assign mode_normal            = mode_q;   // [RL20]
    assign background_debug_state = debug_q;  // [RL21]

    // AHB address phase: single word transfers, no wait states.
    assign addr_phase = hsel & hready & (htrans == `MLSI_HTRANS_NONSEQ);
    assign hreadyout  = 1'b1;
    assign hresp      = `MLSI_HRESP_OKAY;

    // Read data is prepared in the address phase so it stands from a flip-flop in the data phase.
    always @* begin
        rdata_d = `MLSI_WORD_ZERO;
        case (haddr[3:0])
            `MLSI_OFF_CTRL: rdata_d[3:0] = ctrl_q;
            `MLSI_OFF_STATUS: begin
                rdata_d[`MLSI_ST_FAULT_MSB:`MLSI_ST_FAULT_LSB] = fault_vec;
                rdata_d[`MLSI_ST_MODE_BIT]     = mode_q;
                rdata_d[`MLSI_ST_DEBUG_BIT]    = debug_q;
                rdata_d[`MLSI_ST_INTERNAL_BIT] = ch_internal;
                rdata_d[`MLSI_ST_RSVD_BIT]     = sel_reserved;
            end
            `MLSI_OFF_MODE: rdata_d[`MLSI_MODE_BIT] = mode_q;
            `MLSI_OFF_CHAN: rdata_d[8:0] = {ch_idx, channel_select_field};
            default:        rdata_d = `MLSI_WORD_ZERO;
        endcase
    end

    // Bus slave state; unmapped writes are dropped and unmapped reads return zero.
    always @(posedge clk) begin
        if (!rstn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 4'h0;
            rdata_q   <= `MLSI_WORD_ZERO;
            ctrl_q    <= `MLSI_CTRL_RESET;  // [RL4]
        end else begin
            wr_pend_q <= addr_phase & hwrite & (haddr[31:4] == 28'h0000000);
            wr_addr_q <= haddr[3:0];
            if (addr_phase && !hwrite) begin
                rdata_q <= (haddr[31:4] == 28'h0000000) ? rdata_d : `MLSI_WORD_ZERO;
            end
            if (wr_pend_q && (wr_addr_q == `MLSI_OFF_CTRL)) begin
                ctrl_q <= hwdata[3:0];
            end
        end
    end
    assign hrdata = rdata_q;

endmodule

// *** tb/mlsi_monitor.sv ***
// Concurrent checks on the routing of the interconnect, bound to its top module.
`timescale 1ns/1ps
module mlsi_chk (
    input wire        clk, rstn, pwm_reload_a, trigger_unit_reload, glb_load_ok,
    input wire        trigger_unit_reload_in, trigger_unit_load_ok, async_reload_qualifier,
    input wire        converter_restart, converter_load_ok, converter_seq_abort,
    input wire        gate_driver_unit_reload, gate_driver_unit_phase_mux_sel,
    input wire        drv_overcurrent, drv_overvoltage, pwm_fault_input_0, pwm_fault_input_1,
    input wire        pwm_fault_input_4, pwm_async_event, debug_erase_flash_cmd,
    input wire        flash_erase_all_req, flash_clkdiv_force, mode_select_input,
    input wire        mode_normal, background_debug_state,
    input wire [1:0]  drv_desaturation, high_side_gate, low_side_gate, pwm_async_event_edge_sel,
    input wire [2:0]  high_voltage_port_input,
    input wire [11:9] converter_external_channel,
    input wire [3:0]  pwm_channel,
    input wire [7:0]  flash_clock_divider_value
);
    // Everything runs on the bus clock and rests while reset is applied.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_abort_idle: assert property (
        !converter_seq_abort && !async_reload_qualifier) else $error("Tied input raised.");
    chk_restart_fanout: assert property (
        converter_restart == trigger_unit_reload && gate_driver_unit_reload == trigger_unit_reload)
        else $error("Reload fan-out wrong.");
    chk_load_ok_fanout: assert property (
        converter_load_ok == glb_load_ok && trigger_unit_load_ok == glb_load_ok
        && gate_driver_unit_phase_mux_sel == glb_load_ok) else $error("Load-ok fan-out wrong.");
    chk_reload_a_only: assert property (
        trigger_unit_reload_in == pwm_reload_a) else $error("Trigger unit reload wrong.");
    chk_gate_order: assert property (
        high_side_gate == {pwm_channel[2], pwm_channel[0]}
        && low_side_gate == {pwm_channel[3], pwm_channel[1]}) else $error("Gate order wrong.");
    chk_fault_split: assert property (
        drv_overcurrent && !drv_overvoltage && drv_desaturation == 2'h0 |->
        pwm_fault_input_0 != pwm_fault_input_4 && pwm_fault_input_1 == pwm_fault_input_0)
        else $error("Overcurrent not routed to one fault.");
    chk_fault_quiet: assert property (
        !drv_overcurrent && !drv_overvoltage |-> !pwm_fault_input_4
        && {pwm_fault_input_1, pwm_fault_input_0} == drv_desaturation)
        else $error("Fault raised without cause.");
    chk_pwm_ties: assert property (
        !pwm_async_event && pwm_async_event_edge_sel == 2'h3) else $error("PWM ties wrong.");
    chk_erase_force: assert property (
        debug_erase_flash_cmd |-> flash_erase_all_req && flash_clkdiv_force
        && flash_clock_divider_value == 8'h05) else $error("Erase hookup wrong.");
    chk_hv_sync: assert property (
        $past(rstn, 2) && $past(rstn) |->
        converter_external_channel == $past(high_voltage_port_input, 2))
        else $error("High-voltage input not on its channel.");
    chk_mode_capture: assert property (
        $rose(rstn) |=> mode_normal == $past(mode_select_input, 2)
        && background_debug_state == !mode_normal) else $error("Mode not captured.");
    // Main scenarios that the bench is expected to reach.
    cover property ($rose(rstn) ##1 !mode_normal);
    cover property (drv_overcurrent && pwm_fault_input_4);
    cover property (debug_erase_flash_cmd);
endmodule

bind mlsi_top mlsi_chk u_mlsi_chk (.*);

// *** tb/mlsi_far_model.sv ***
// Event producers of the loop: PWM generator, trigger unit, timer and load-ok source.
`timescale 1ns/1ps
module mlsi_far_model (
    input  wire       clk,
    input  wire       ev_go,
    input  wire [2:0] ev_sel,
    output logic [6:0] ev_pulse
);
    // One event at a time, one bus cycle wide, as the real producers emit them.
    always @(posedge clk) begin
        ev_pulse <= ev_go ? (7'h01 << ev_sel) : 7'h00;
    end
endmodule

// *** tb/tb_motor_loop_signal_interconnect.sv ***
// Self-checking bench for the motor-loop interconnect and its control registers.
`timescale 1ns/1ps
`include "mlsi_regs.vh"
module tb_motor_loop_signal_interconnect;
    logic clk = 1'b0, rstn = 1'b0, hsel = 1'b1, hwrite = 1'b0, ev_go = 1'b0;
    logic drv_overcurrent = 1'b0, drv_overvoltage = 1'b0, low_side_supply_undervoltage = 1'b0;
    logic external_fault_pin = 1'b0, internal_reference_osc_clock = 1'b0;
    logic debug_erase_flash_cmd = 1'b0, debug_exit = 1'b0, mode_select_input = 1'b0;
    logic [1:0]  htrans = 2'h0, drv_desaturation = 2'h0, drv_phase_status = 2'h0;
    logic [2:0]  hsize = 3'h2, ev_sel = 3'h0, high_voltage_port_input = 3'h0;
    logic [3:0]  pwm_channel = 4'h0;
    logic [5:0]  channel_select_field = 6'h00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [6:0]  ev_pulse;
    wire  [31:0] hrdata;
    wire  hready, hreadyout, hresp, trigger_unit_reload_in, trigger_unit_load_ok;
    wire  async_reload_qualifier, converter_restart, converter_load_ok, converter_seq_abort;
    wire  converter_trigger, gate_driver_unit_reload, gate_driver_unit_phase_mux_sel;
    wire  sel_temp_bandgap, sel_phase_mux, sel_dc_link, sel_supply_sense, sel_dvbe_temp;
    wire  sel_reserved, pwm_fault_input_0, pwm_fault_input_1, pwm_fault_input_2;
    wire  pwm_fault_input_3, pwm_fault_input_4, pwm_fault_input_5, pwm_async_event;
    wire  debug_serial_clock, debug_fast_clock, flash_erase_all_req, flash_clkdiv_force;
    wire  mode_normal, background_debug_state, pwm_reload_a, pwm_reload_b, pwm_reload_c;
    wire  trigger_unit_reload, trigger_unit_output_0, timer_zero_oc2, glb_load_ok;
    wire  [1:0]  high_side_gate, low_side_gate, pwm_async_event_edge_sel;
    wire  [2:0]  pwm_phase_status;
    wire  [7:0]  flash_clock_divider_value;
    wire  [11:9] converter_external_channel;
    int   miscompares = 0, compares = 0, cycles = 0;

    // The model's one-hot pulse vector fans out to the individual event inputs.
    assign {glb_load_ok, timer_zero_oc2, trigger_unit_output_0, trigger_unit_reload,
            pwm_reload_c, pwm_reload_b, pwm_reload_a} = ev_pulse;
    assign hready = hreadyout;
    mlsi_top u_mlsi_top (.*);
    mlsi_far_model u_mlsi_far_model (.clk(clk), .ev_go(ev_go), .ev_sel(ev_sel), .ev_pulse(ev_pulse));

    // Bus clock and a cycle ceiling far above the few hundred cycles the run needs.
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic conclude();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check_vec(input string what, input logic [11:0] exp, input logic [11:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One single word transfer; hsel stays up, an idle htrans keeps the slave quiet.
    task automatic ahb(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        haddr <= {28'h0, a};
        hwrite <= wr;
        htrans <= `MLSI_HTRANS_NONSEQ;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic do_reset(input logic pin);
        rstn <= 1'b0;
        mode_select_input <= pin;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        check_vec("mode and debug", {10'h0, pin, !pin}, {10'h0, mode_normal, background_debug_state});
        @(posedge clk);
    endtask

    // Leave debug, switch special to normal by software, then reset into normal mode.
    task automatic t_mode();
        debug_exit <= 1'b1;
        @(posedge clk);
        debug_exit <= 1'b0;
        ahb(1'b1, `MLSI_OFF_MODE, 32'h1);
        ahb(1'b1, `MLSI_OFF_MODE, 32'h0);
        ahb(1'b0, `MLSI_OFF_MODE, 32'h0);
        check_word("mode reg", 32'h1, rd);
        check_vec("mode pins", 12'h2, {10'h0, mode_normal, background_debug_state});
        do_reset(1'b1);
    endtask

    // Control reset value, read back, and a write to the read-only status register that must stay inert.
    task automatic t_regs();
        ahb(1'b0, `MLSI_OFF_CTRL, 32'h0);
        check_word("ctrl reset", {28'h0, `MLSI_CTRL_RESET}, rd);
        ahb(1'b1, `MLSI_OFF_STATUS, 32'hf);
        ahb(1'b0, `MLSI_OFF_CTRL, 32'h0);
        check_word("ctrl after stray", 32'h1, rd);
        ahb(1'b1, `MLSI_OFF_CTRL, 32'hf);
        ahb(1'b0, `MLSI_OFF_CTRL, 32'h0);
        check_word("ctrl", 32'hf, rd);
        check_vec("hresp", 12'h0, {11'h0, hresp});
    endtask

    // Every trigger source code against every event of the loop.
    task automatic t_events();
        logic t;
        for (int sel = 0; sel < 4; sel++) begin
            ahb(1'b1, `MLSI_OFF_CTRL, 32'(sel));
            for (int s = 0; s < 7; s++) begin
                ev_sel <= 3'(s);
                ev_go <= 1'b1;
                @(posedge clk);
                ev_go <= 1'b0;
                @(negedge clk);
                t = (sel == 0 && s == 5) || (sel == 1 && s == 4) || (sel == 2 && s == 0);
                check_vec("events", {8'h0, t, s == 3, s == 6, s == 0}, {8'h0, converter_trigger,
                    converter_restart, converter_load_ok, trigger_unit_reload_in});
                @(posedge clk);
            end
        end
    endtask

    // All desaturation, overcurrent and overvoltage combinations under each setting of the two assign bits.
    task automatic t_faults();
        logic [4:0] f;
        for (int c = 0; c < 4; c++) begin
            ahb(1'b1, `MLSI_OFF_CTRL, 32'(c * 4 + 1));
            for (int v = 0; v < 16; v++) begin
                {drv_desaturation, drv_overcurrent, drv_overvoltage} <= 4'(v);
                low_side_supply_undervoltage <= v[0];
                @(negedge clk);
                f[0] = v[2] | (v[1] & c[1]);
                f[1] = v[3] | (v[1] & c[1]) | (v[0] & c[0]);
                f[2] = 1'b0;
                f[3] = v[0];
                f[4] = (v[0] & !c[0]) | (v[1] & !c[1]);
                check_vec("faults", {7'h0, f}, {7'h0, pwm_fault_input_4, pwm_fault_input_3,
                    pwm_fault_input_2, pwm_fault_input_1, pwm_fault_input_0});
                @(posedge clk);
            end
        end
        external_fault_pin <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check_vec("pwm_fault_input_5", 12'h1, {11'h0, pwm_fault_input_5});
        @(posedge clk);
        ahb(1'b0, `MLSI_OFF_STATUS, 32'h0);
        check_word("status", 32'h12b, rd);
    endtask

    // Internal channel decode, then the synchronised high-voltage inputs.
    task automatic t_chan();
        logic i;
        for (int f = 0; f < 24; f++) begin
            channel_select_field <= 6'(f);
            @(negedge clk);
            i = (f / 8 == 1);
            check_vec("channel", {6'h0, i && (f % 8 == 5 || f % 8 == 6), i && f % 8 == 7,
                i && f % 8 == 4, i && f % 8 == 3, i && f % 8 == 1, i && f % 8 == 0},
                {6'h0, sel_reserved, sel_dvbe_temp, sel_supply_sense, sel_dc_link,
                sel_phase_mux, sel_temp_bandgap});
            @(posedge clk);
        end
        for (int v = 5; v > 1; v -= 3) begin
            high_voltage_port_input <= 3'(v);
            repeat (2) @(posedge clk);
            @(negedge clk);
            check_vec("hv channels", 12'(v), {9'h0, converter_external_channel});
            @(posedge clk);
        end
        ahb(1'b0, `MLSI_OFF_CHAN, 32'h0);
        check_word("chan reg", 32'h1d7, rd);
    endtask

    // PWM channels to gates and phase status to the status inputs.
    task automatic t_gates();
        for (int p = 0; p < 16; p++) begin
            pwm_channel <= 4'(p);
            drv_phase_status <= 2'(p);
            @(negedge clk);
            check_vec("gates", {5'h0, 1'b1, 2'(p), p[2], p[0], p[3], p[1]},
                {5'h0, pwm_phase_status, high_side_gate, low_side_gate});
            @(posedge clk);
        end
    endtask

    // Erase hookup and debug clock sources; the bus clock is left untouched throughout.
    task automatic t_debug();
        debug_erase_flash_cmd <= 1'b1;
        internal_reference_osc_clock <= 1'b1;
        @(negedge clk);
        check_vec("erase", 12'h05e, {flash_clock_divider_value, flash_erase_all_req,
            flash_clkdiv_force, debug_serial_clock, debug_fast_clock});
        @(posedge clk);
        debug_erase_flash_cmd <= 1'b0;
        internal_reference_osc_clock <= 1'b0;
        #1;
        check_vec("debug idle", 12'h1, {8'h0, flash_erase_all_req, flash_clkdiv_force,
            debug_serial_clock, debug_fast_clock});
        @(posedge clk);
    endtask

    // Main sequence: reset into special mode, then one scenario after another.
    initial begin
        do_reset(1'b0);
        t_mode();
        t_regs();
        t_events();
        t_faults();
        t_chan();
        t_gates();
        t_debug();
        conclude();
    end
endmodule
